// [design/rgb_panel_timing_receiver.sv]
`timescale 1ns/1ps
module rgb_panel_timing_receiver (
  rgb_link_if.panel                       link,
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  output logic [5:0]                      red_out,
  output logic [5:0]                      green_out,
  output logic [5:0]                      blue_out,
  output logic [9:0]                      pixel_x,
  output logic [9:0]                      line_y,
  output logic                            pixel_strobe,
  output logic                            frame_done,
  output logic                            white_screen,
  output logic                            skew_drop
);
  localparam int CW = rgb_timing_pkg::CNT_W;
  logic           rst_m_r, rst_s_r, prst_r;
  logic           hs_d_r, vs_d_r, de_r;
  logic [17:0]    pd_r;
  logic [CW-1:0]  dot_r, line_r, px_r, act_r;
  logic           vs_seen_r, skip_r;
  logic [3:0]     frames_r;
  logic           wpix_r;
  logic [17:0]    pix_r;
  logic [CW-1:0]  pxq_r;
  logic           pstb_r, fdone_r, drop_r;
  logic           stb_t_r, fd_t_r, dr_t_r;
  logic [2:0]     stb_s_r, fd_s_r, dr_s_r;
  logic           hs_fall, vs_fall;
  logic [29:0]    cap_r;
  logic [29:0]    cap_s_r;

  // Sys reset and pin reset meet in the pixel domain
  always_ff @(posedge link.pixel_clk) begin
    rst_m_r <= sys_rst | ~link.panel_reset_n;
    rst_s_r <= rst_m_r;
    prst_r  <= rst_s_r;
  end

  // One capture edge for every link input
  always_ff @(posedge link.pixel_clk) begin
    if (prst_r) begin
      hs_d_r <= 1'b1;
      vs_d_r <= 1'b1;
      de_r   <= 1'b0;
      pd_r   <= 18'h0_0000;
    end else begin
      hs_d_r <= link.line_sync_n;
      vs_d_r <= link.frame_sync_n;
      de_r   <= link.pixel_valid;
      pd_r   <= link.pixel_data_bus;
    end
  end

  assign hs_fall = hs_d_r & ~link.line_sync_n;
  assign vs_fall = vs_d_r & ~link.frame_sync_n;

  // Dot and line counters from the sync falling edges
  always_ff @(posedge link.pixel_clk) begin
    if (prst_r) begin
      dot_r     <= '0;
      line_r    <= '0;
      vs_seen_r <= 1'b0;
      skip_r    <= 1'b0;
      drop_r    <= 1'b0;
    end else begin
      drop_r <= 1'b0;
      dot_r  <= (dot_r == CW'(rgb_timing_pkg::LINE_PERIOD_MAX)) ? dot_r
                : dot_r + 1'b1;
      if (vs_fall) begin
        vs_seen_r <= 1'b1;
        // Frame edge must trail the line edge by under a line
        skip_r <= (dot_r >= CW'(rgb_timing_pkg::LINE_PERIOD_MAX));
        line_r <= '0;
      end
      if (hs_fall) begin
        dot_r <= '0;
        if (skip_r) begin
          skip_r <= 1'b0;
          drop_r <= 1'b1;
        end else if (vs_fall || !vs_seen_r) begin
          line_r <= '0;
        end else if (line_r < CW'(rgb_timing_pkg::FRAME_PERIOD_MAX)) begin
          line_r <= line_r + 1'b1;
        end
      end
    end
  end

  // Pixel index within the active line
  always_ff @(posedge link.pixel_clk) begin
    if (prst_r || hs_fall) begin
      px_r <= '0;
    end else if (de_r &&
                 px_r < CW'(rgb_timing_pkg::LINE_ACTIVE_PIXELS)) begin
      px_r <= px_r + 1'b1;
    end
  end

  // Active line index, counted at the line sync fall that ends each line with valid dots
  always_ff @(posedge link.pixel_clk) begin
    if (prst_r || vs_fall) begin
      act_r <= '0;
    end else if (hs_fall && px_r != '0 &&
                 act_r < CW'(rgb_timing_pkg::FRAME_ACTIVE_LINES)) begin
      act_r <= act_r + 1'b1;
    end
  end

  // Tenth frame sync turns on white while shutdown is low
  always_ff @(posedge link.pixel_clk) begin
    if (prst_r) begin
      frames_r <= 4'h0;
      wpix_r   <= 1'b0;
      fdone_r  <= 1'b0;
    end else begin
      fdone_r <= vs_fall;
      if (vs_fall && frames_r != 4'(rgb_timing_pkg::WHITE_AFTER_FRAMES)) begin
        frames_r <= frames_r + 4'h1;
      end
      wpix_r <= ~link.shutdown_ctl &&
                frames_r == 4'(rgb_timing_pkg::WHITE_AFTER_FRAMES);
    end
  end

  // Pixel capture honours the valid qualifier
  always_ff @(posedge link.pixel_clk) begin
    if (prst_r) begin
      pix_r  <= 18'h0_0000;
      pxq_r  <= '0;
      pstb_r <= 1'b0;
    end else begin
      pstb_r <= de_r &&
                px_r < CW'(rgb_timing_pkg::LINE_ACTIVE_PIXELS) &&
                act_r < CW'(rgb_timing_pkg::FRAME_ACTIVE_LINES);
      // Index travels with its pixel, px_r has already moved on
      if (de_r) begin
        pix_r <= pd_r;
        pxq_r <= px_r;
      end
    end
  end

  // Events leave the pixel domain as toggles
  always_ff @(posedge link.pixel_clk) begin
    if (prst_r) begin
      stb_t_r <= 1'b0;
      fd_t_r  <= 1'b0;
      dr_t_r  <= 1'b0;
      cap_r   <= '0;
    end else begin
      if (pstb_r) begin
        stb_t_r <= ~stb_t_r;
        cap_r   <= {pix_r, pxq_r[5:0], act_r[5:0]};
      end
      if (fdone_r) begin
        fd_t_r <= ~fd_t_r;
      end
      if (drop_r) begin
        dr_t_r <= ~dr_t_r;
      end
    end
  end

  // Pixel rate is far below clk, so the word is stable at each toggle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stb_s_r <= 3'b000;
      fd_s_r  <= 3'b000;
      dr_s_r  <= 3'b000;
      cap_s_r <= '0;
    end else begin
      stb_s_r <= {stb_s_r[1:0], stb_t_r};
      fd_s_r  <= {fd_s_r[1:0], fd_t_r};
      dr_s_r  <= {dr_s_r[1:0], dr_t_r};
      if (stb_s_r[2] != stb_s_r[1]) begin
        cap_s_r <= cap_r;
      end
    end
  end

  logic wp_m_r, wp_s_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_m_r       <= 1'b0;
      wp_s_r       <= 1'b0;
      pixel_strobe <= 1'b0;
      frame_done   <= 1'b0;
      skew_drop    <= 1'b0;
    end else begin
      wp_m_r       <= wpix_r;
      wp_s_r       <= wp_m_r;
      pixel_strobe <= stb_s_r[2] != stb_s_r[1];
      frame_done   <= fd_s_r[2] != fd_s_r[1];
      skew_drop    <= dr_s_r[2] != dr_s_r[1];
    end
  end

  // Colour split
  assign red_out      = wp_s_r ? 6'h3f : cap_s_r[29:24];
  assign green_out    = wp_s_r ? 6'h3f : cap_s_r[23:18];
  assign blue_out     = wp_s_r ? 6'h3f : cap_s_r[17:12];
  assign pixel_x      = {4'h0, cap_s_r[11:6]};
  assign line_y       = {4'h0, cap_s_r[5:0]};
  assign white_screen = wp_s_r;
endmodule

// [design/rgb_timing_pkg.sv]
package rgb_timing_pkg;
  localparam int PIX_W          = 18;
  localparam int COLOR_W        = 6;
  localparam int RED_MSB        = 17;
  localparam int GREEN_MSB      = 11;
  localparam int BLUE_MSB       = 5;
  localparam int LINE_SYNC_WIDTH    = 10;
  localparam int LINE_BACK_PORCH    = 20;
  localparam int LINE_DATA_OFFSET   = LINE_SYNC_WIDTH + LINE_BACK_PORCH;
  localparam int LINE_ACTIVE_PIXELS = 240;
  localparam int LINE_FRONT_PORCH   = 10;
  localparam int LINE_PERIOD_DOTS   = 280;
  localparam int LINE_PERIOD_MIN    = 260;
  localparam int LINE_PERIOD_MAX    = 300;
  localparam int FRAME_SYNC_WIDTH   = 2;
  localparam int FRAME_BACK_PORCH   = 2;
  localparam int FRAME_DATA_OFFSET  = FRAME_SYNC_WIDTH + FRAME_BACK_PORCH;
  localparam int FRAME_ACTIVE_LINES = 320;
  localparam int FRAME_FRONT_PORCH  = 2;
  localparam int FRAME_PERIOD_LINES = 326;
  localparam int FRAME_PERIOD_MIN   = 323;
  localparam int FRAME_PERIOD_MAX   = 340;
  localparam int WHITE_AFTER_FRAMES = 10;
  localparam real PCLK_MHZ_MIN      = 5.02;
  localparam real PCLK_MHZ_NOM      = 5.48;
  localparam real PCLK_MHZ_MAX      = 5.93;
  localparam real SYS_CLK_MHZ       = 200.0;
  // System cycles per pixel clock, half period rounded down
  localparam int PCLK_HALF_DIV = int'(SYS_CLK_MHZ / PCLK_MHZ_NOM) / 2;
  localparam int CNT_W          = 10;
  localparam logic [PIX_W-1:0] WHITE_PIXEL = 18'h3_ffff;
endpackage

// [design/rgb_link_if.sv]
`timescale 1ns/1ps
interface rgb_link_if;
  logic        pixel_clk;
  logic        panel_reset_n;
  logic        line_sync_n;
  logic        frame_sync_n;
  logic        pixel_valid;
  logic [17:0] pixel_data_bus;
  logic        shutdown_ctl;
  modport ctrl (
    output pixel_clk,
    output panel_reset_n,
    output line_sync_n,
    output frame_sync_n,
    output pixel_valid,
    output pixel_data_bus,
    output shutdown_ctl
  );
  modport panel (
    input pixel_clk,
    input panel_reset_n,
    input line_sync_n,
    input frame_sync_n,
    input pixel_valid,
    input pixel_data_bus,
    input shutdown_ctl
  );
endinterface

// [design/rgb_timing_controller.sv]
`timescale 1ns/1ps
module rgb_timing_controller (
  rgb_link_if.ctrl          link,
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         panel_enable,
  input  wire logic         shutdown_req,
  input  wire logic [17:0]  pixel_in,
  output logic              pixel_req
);
  localparam int CW = rgb_timing_pkg::CNT_W;
  logic [7:0]    div_r;
  logic          pclk_r, rise;
  logic [CW-1:0] dot_r, line_r;
  logic          en_m_r, en_s_r, hs_r, vs_r, de_r;
  logic [17:0]   pd_r;
  logic          act;

  // Divider keeps the pixel clock running through blanking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_r  <= 8'h00;
      pclk_r <= 1'b0;
    end else if (div_r == 8'(rgb_timing_pkg::PCLK_HALF_DIV - 1)) begin
      div_r  <= 8'h00;
      pclk_r <= ~pclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  // Link outputs change on the falling pixel edge
  assign rise = (div_r == 8'(rgb_timing_pkg::PCLK_HALF_DIV - 1)) & pclk_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_m_r <= 1'b0;
      en_s_r <= 1'b0;
    end else begin
      en_m_r <= panel_enable;
      en_s_r <= en_m_r;
    end
  end

  // Nominal line and frame raster
  always_ff @(posedge clk) begin
    if (sys_rst || !en_s_r) begin
      dot_r  <= '0;
      line_r <= '0;
    end else if (rise) begin
      if (dot_r == CW'(rgb_timing_pkg::LINE_PERIOD_DOTS - 1)) begin
        dot_r  <= '0;
        line_r <= (line_r == CW'(rgb_timing_pkg::FRAME_PERIOD_LINES - 1))
                  ? '0 : line_r + 1'b1;
      end else begin
        dot_r <= dot_r + 1'b1;
      end
    end
  end

  // Active area: 30 dots and 4 lines past sync
  assign act = dot_r >= CW'(rgb_timing_pkg::LINE_DATA_OFFSET) &&
               dot_r < CW'(rgb_timing_pkg::LINE_DATA_OFFSET +
                           rgb_timing_pkg::LINE_ACTIVE_PIXELS) &&
               line_r >= CW'(rgb_timing_pkg::FRAME_DATA_OFFSET) &&
               line_r < CW'(rgb_timing_pkg::FRAME_DATA_OFFSET +
                            rgb_timing_pkg::FRAME_ACTIVE_LINES);
  assign pixel_req = act & rise & en_s_r;

  always_ff @(posedge clk) begin
    // Syncs idle high while disabled, so enable gives a clean first edge
    if (sys_rst || !en_s_r) begin
      hs_r <= 1'b1;
      vs_r <= 1'b1;
      de_r <= 1'b0;
      pd_r <= 18'h0_0000;
    end else if (rise) begin
      // Both syncs fall at dot 0, skew zero
      hs_r <= ~(dot_r < CW'(rgb_timing_pkg::LINE_SYNC_WIDTH));
      vs_r <= ~(line_r < CW'(rgb_timing_pkg::FRAME_SYNC_WIDTH));
      de_r <= act;
      pd_r <= act ? pixel_in : 18'h0_0000;
    end
  end

  // Porches follow from the raster: back 20 dots and 2 lines, front 10 dots and 2 lines
  assign link.pixel_clk      = pclk_r;
  assign link.panel_reset_n  = en_s_r;
  assign link.line_sync_n    = hs_r;
  assign link.frame_sync_n   = vs_r;
  assign link.pixel_valid    = de_r;
  assign link.pixel_data_bus = pd_r;
  assign link.shutdown_ctl   = shutdown_req;
endmodule

// [test/rgb_link_chk.sv]
`timescale 1ns/1ps
module rgb_link_chk (
  input wire logic        pixel_clk,
  input wire logic        panel_reset_n,
  input wire logic        line_sync_n,
  input wire logic        frame_sync_n,
  input wire logic        pixel_valid,
  input wire logic [17:0] pixel_data_bus
);
  logic       pl_r;
  logic       pf_r;
  logic       seen_r;
  logic       fseen_r;
  logic [9:0] dot_r;
  logic [9:0] ln_r;
  logic [9:0] run_r;
  default clocking cb @(posedge pixel_clk); endclocking
  default disable iff (!panel_reset_n);
  always_ff @(posedge pixel_clk) begin
    pl_r <= line_sync_n;
    pf_r <= frame_sync_n;
    run_r <= pixel_valid ? run_r + 10'd1 : 10'd0;
    if (!panel_reset_n) begin
      seen_r <= 1'b0;
      fseen_r <= 1'b0;
      ln_r <= 10'd0;
    end else if (pl_r && !line_sync_n) begin
      seen_r <= 1'b1;
      fseen_r <= fseen_r | (pf_r && !frame_sync_n);
      ln_r <= (pf_r && !frame_sync_n) ? 10'd0 : ln_r + 10'd1;
    end
  end
  always_ff @(posedge pixel_clk) begin
    dot_r <= (pl_r && !line_sync_n) ? 10'd1 : dot_r + 10'd1;
  end
  chk_line_sync_width: assert property ($fell(line_sync_n) |->
    (!line_sync_n)[*8] ##1 (!line_sync_n)[*2] ##1 line_sync_n)
    else $error("line sync width wrong");
  chk_frame_on_line: assert property ($fell(frame_sync_n) |->
    $fell(line_sync_n)) else $error("frame sync off line start");
  chk_frame_sync_width: assert property ($fell(frame_sync_n) |->
    ##[560:560] $rose(frame_sync_n)) else $error("frame sync width wrong");
  chk_valid_start: assert property ($rose(pixel_valid) |->
    !$past(line_sync_n, 30) && $past(line_sync_n, 31))
    else $error("first pixel offset wrong");
  chk_valid_run: assert property ($fell(pixel_valid) |->
    run_r == 10'd240) else $error("active pixel count wrong");
  chk_valid_no_sync: assert property (pixel_valid |-> line_sync_n)
    else $error("valid during line sync");
  chk_line_period: assert property ($fell(line_sync_n) && seen_r |->
    dot_r == 10'd280) else $error("line period wrong");
  chk_active_lines: assert property (pixel_valid |->
    ln_r >= 10'd4 && ln_r <= 10'd323) else $error("valid outside lines");
  chk_frame_period: assert property ($fell(frame_sync_n) && fseen_r |->
    ln_r == 10'd325) else $error("frame period wrong");
endmodule

// [test/rgb_panel_timing_receiver_test.sv]
`timescale 1ns/1ps
module rgb_panel_timing_receiver_test;
  typedef struct packed {logic [17:0] pix; logic [17:0] rgb;} row_s;
  row_s        rows [4];
  logic        clk, sys_rst, panel_enable, shutdown_req, pixel_req;
  logic [17:0] pixel_in, vpix;
  logic [5:0]  red_out, green_out, blue_out;
  logic [9:0]  pixel_x, line_y;
  logic        pixel_strobe, frame_done, white_screen, skew_drop;
  logic        pl_r, pv_r, pf_r;
  int          n_fail, checks_done, req_cnt, k, t, nfd, nsd;
  int          dot, hp, hs_cnt, vstart, vcnt, lno, vline;
  rgb_link_if link ();
  rgb_timing_controller rgb_timing_controller_i (.link(link), .clk(clk),
    .sys_rst(sys_rst), .panel_enable(panel_enable),
    .shutdown_req(shutdown_req), .pixel_in(pixel_in),
    .pixel_req(pixel_req));
  rgb_panel_timing_receiver rgb_panel_timing_receiver_i (.link(link),
    .clk(clk), .sys_rst(sys_rst), .red_out(red_out), .green_out(green_out),
    .blue_out(blue_out), .pixel_x(pixel_x), .line_y(line_y),
    .pixel_strobe(pixel_strobe), .frame_done(frame_done),
    .white_screen(white_screen), .skew_drop(skew_drop));
  rgb_link_chk rgb_link_chk_i (.pixel_clk(link.pixel_clk),
    .panel_reset_n(link.panel_reset_n), .line_sync_n(link.line_sync_n),
    .frame_sync_n(link.frame_sync_n), .pixel_valid(link.pixel_valid),
    .pixel_data_bus(link.pixel_data_bus));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Next word is set up before the request that takes it
  always @(posedge clk) begin
    if (pixel_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      pixel_in <= rows[(req_cnt + 1) % 4].pix;
    end
    if (frame_done === 1'b1) nfd <= nfd + 1;
    if (skew_drop === 1'b1) nsd <= nsd + 1;
  end
  // Wire monitor, same edge the panel samples on
  always @(posedge link.pixel_clk) begin
    pl_r <= link.line_sync_n;
    pv_r <= link.pixel_valid;
    pf_r <= link.frame_sync_n;
    if (pl_r && !link.line_sync_n) begin
      hp <= dot;
      dot <= 1;
      hs_cnt <= 1;
      lno <= (pf_r && !link.frame_sync_n) ? 0 : lno + 1;
    end else begin
      dot <= dot + 1;
      if (!link.line_sync_n) hs_cnt <= hs_cnt + 1;
    end
    if (link.pixel_valid && !pv_r && vcnt == 0) begin
      vstart <= dot;
      vline <= lno;
      vpix <= link.pixel_data_bus;
    end
    if (link.pixel_valid) vcnt <= vcnt + 1;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    rows[0] = '{18'h3_f000, 18'h3_f000};
    rows[1] = '{18'h0_0fc0, 18'h0_0fc0};
    rows[2] = '{18'h0_003f, 18'h0_003f};
    rows[3] = '{18'h0_1041, 18'h0_1041};
    {pl_r, pv_r, pf_r} = 3'b101;
    {dot, hp, hs_cnt, vstart, vcnt, lno, vline, nfd, nsd} = '0;
    {n_fail, checks_done, req_cnt} = '0;
    sys_rst = 1;
    panel_enable = 0;
    shutdown_req = 1;
    pixel_in = rows[0].pix;
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    panel_enable <= 1;
    for (k = 0; k < 240; k++) begin
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (pixel_strobe !== 1'b1 && t < 60000);
      check("colour", {red_out, green_out, blue_out}, rows[k % 4].rgb);
      check("pixel_x", pixel_x, k % 64);
      check("line_y", line_y, 0);
    end
    $display("test pixel stream done");
    check("line sync width", hs_cnt, 10);
    check("line period", hp, 280);
    check("data offset", vstart, 30);
    check("first line", vline, 4);
    check("valid count", vcnt, 240);
    check("wire pixel", vpix, rows[0].pix);
    check("frames", nfd, 1);
    check("drops", nsd, 0);
    check("white", white_screen, 0);
    $display("test timing done");
    @(posedge clk) shutdown_req <= 0;
    @(negedge clk);
    check("shutdown", link.shutdown_ctl, 0);
    panel_enable <= 0;
    repeat (200) @(posedge clk);
    check("panel reset", link.panel_reset_n, 0);
    sys_rst <= 1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    check("idle", {link.line_sync_n, link.frame_sync_n, link.pixel_valid},
      3'b110);
    $display("test reset done");
    print_verdict();
  end
endmodule
